// ==== hdl/sgcs_pkg.sv ====
// Supervisor register map, fields, reset values and types
package sgcs_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] TRAVEL_OFS = 8'h04;
  localparam logic [7:0] HOLD_OFS = 8'h08;
  localparam logic [7:0] BYPASS_OFS = 8'h0c;
  localparam logic [7:0] SYNC_OFS = 8'h10;
  localparam logic [7:0] STATUS_OFS = 8'h14;
  localparam logic [7:0] AUTH_CNT_OFS = 8'h18;
  localparam logic [7:0] OVL_CNT_OFS = 8'h1c;
  localparam logic [7:0] LOCK_CNT_OFS = 8'h20;
  localparam logic [7:0] CMD_OFS = 8'h24;
  localparam logic [7:0] TRIP_MASK_OFS = 8'h28;
  // Control register fields
  localparam int AUTH_LSB = 0;
  localparam int BYP_MODE_LSB = 2;
  localparam int TRIP_LATCH_BIT = 4;
  localparam int OVR_EN_BIT = 5;
  localparam int OVR_POS_BIT = 6;
  localparam int AUX_ASSIGNED_BIT = 7;
  localparam int SYNC_ASSIGNED_BIT = 8;
  localparam int PARAM_LOCK_BIT = 9;
  localparam int ILK_OPEN_LSB = 10;
  localparam int ILK_CLOSE_LSB = 13;
  localparam int CTRL_W = 16;
  localparam logic [CTRL_W-1:0] CTRL_RST = 16'h0083;
  // Command bits, write only, self clearing
  localparam int CMD_OPEN_BIT = 0;
  localparam int CMD_CLOSE_BIT = 1;
  localparam int CMD_BYP_ARM_BIT = 2;
  localparam int CMD_TRIP_RST_BIT = 3;
  // Default timer loads in clock ticks
  localparam logic [31:0] TRAVEL_RST = 32'h000f4240;
  localparam logic [31:0] HOLD_RST = 32'h00989680;
  localparam logic [31:0] BYPASS_RST = 32'h05f5e100;
  localparam logic [31:0] SYNC_RST = 32'h01312d00;
  localparam int NUM_ILK = 3;
  localparam int CNT_W = 16;
  // Position state codes
  localparam logic [1:0] POS_INTERM = 2'h0;
  localparam logic [1:0] POS_OPEN = 2'h1;
  localparam logic [1:0] POS_CLOSED = 2'h2;
  localparam logic [1:0] POS_DISTURB = 2'h3;
  typedef enum logic [1:0] {AUTH_NONE, AUTH_LOCAL, AUTH_REMOTE, AUTH_BOTH} sgcs_auth_t;
  typedef enum logic [1:0] {BYP_SINGLE, BYP_PERM, BYP_TIMED, BYP_SIGNAL} sgcs_byp_t;
  typedef enum logic [1:0] {ST_IDLE, ST_SYNC_WAIT, ST_MOVE_OPEN, ST_MOVE_CLOSE} sgcs_state_t;
endpackage

// ==== hdl/sgcs_top.sv ====
// Switchgear command supervisor, AHB-Lite slave
`timescale 1ns/100ps
////////////////////////////////////////////////////////////////////////////////
// Function
// - Any switch command starts the travel timer, close only after sync release; position reads intermediate meanwhile.
// - End position in time: success, intermediate cleared same cycle.
// - Travel timer expiry before open position sets fault, clears intermediate.
// - Codes: 0 intermediate, 1 open, 2 closed; each asserts only its flag.
// - Open-side contact not assigned reports position 3, disturbed.
// - Three interlocks per direction, each with an enable bit; any active enabled one blocks it.
// - Protection open and auto-reclose close skip interlocks; separate block input for protection open only.
// - Trip manager ORs only assigned trip requests; it alone drives trip.
// - Trip held for configurable minimum time; option keeps it latched.
// - External close on rising edge, open on level; open wins.
// - With sync assigned, close waits for sync release within wait limit.
// - No sync signal assigned means sync release is always true.
// - Authority none, local, remote or both gates command sources.
// - Bypass modes single, permanent, timed, signal; time applies to single.
// - Manual override replaces derived position; flag shows override active.
// - One command at a time; commands during a running one are rejected, except protection open.
// - Command for the held position is suppressed, panel and remote alike.
// - Close key press gives at most one close pulse however long held.
// - Count rejections: authority, overlap, parameter lock.
// - Close starts travel timer; intermediate, closed in time, else disturbed.
module sgcs_top #(
  parameter int NTRIP = 8,
  parameter int TW = 32
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic aux_open_contact,
  input wire logic key_open,
  input wire logic key_close,
  input wire logic ext_open,
  input wire logic ext_close,
  input wire logic auto_reclose,
  input wire logic sync_release,
  input wire logic bypass_signal,
  input wire logic prot_block,
  input wire logic [2:0] ilk_open,
  input wire logic [2:0] ilk_close,
  input wire logic [NTRIP-1:0] prot_trip,
  output logic open_relay,
  output logic close_relay,
  output logic trip_out,
  output logic [1:0] pos_state,
  output logic pos_open,
  output logic pos_closed,
  output logic pos_interm,
  output logic pos_disturbed,
  output logic command_success,
  output logic pos_fault,
  output logic override_active,
  output logic bypass_active
);
  localparam int NPIN = 15 + NTRIP;

  function automatic logic [sgcs_pkg::CNT_W-1:0] sat_inc(input logic [sgcs_pkg::CNT_W-1:0] v);
    sat_inc = (&v) ? v : v + 1'b1;
  endfunction

  function automatic logic [TW-1:0] tdec(input logic [TW-1:0] v);
    tdec = (v == '0) ? v : v - 1'b1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Pin synchroniser
  logic [NPIN-1:0] pin_meta_r, pin_r, pin_d_r;
  wire [NPIN-1:0] pin_raw = {prot_trip, ilk_close, ilk_open, prot_block, bypass_signal,
                             sync_release, auto_reclose, ext_close, ext_open, key_close,
                             key_open, aux_open_contact};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_meta_r <= '0;
      pin_r <= '0;
      pin_d_r <= '0;
    end else begin
      pin_meta_r <= pin_raw;
      pin_r <= pin_meta_r;
      pin_d_r <= pin_r;
    end
  end
  wire contact = pin_r[0];
  wire [NPIN-1:0] pin_rise = pin_r & ~pin_d_r;
  wire s_ext_open = pin_r[3];
  wire s_sync = pin_r[6];
  wire s_byp_sig = pin_r[7];
  wire s_prot_block = pin_r[8];
  wire [2:0] s_ilk_open = pin_r[11:9];
  wire [2:0] s_ilk_close = pin_r[14:12];
  wire [NTRIP-1:0] s_trip = pin_r[NPIN-1:15];

  ////////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave
  logic [sgcs_pkg::CTRL_W-1:0] ctrl_r;
  logic [TW-1:0] travel_r, hold_r, bypass_r, sync_r;
  logic [NTRIP-1:0] trip_mask_r;
  logic [sgcs_pkg::CNT_W-1:0] auth_cnt_r, ovl_cnt_r, lock_cnt_r;
  logic [7:0] wadr_r;
  logic wr_r;
  logic [31:0] status_w;
  wire ap_valid = hsel && htrans[1] && hready;
  wire wr_ctrl = wr_r && wadr_r == sgcs_pkg::CTRL_OFS;
  wire wr_cmd = wr_r && wadr_r == sgcs_pkg::CMD_OFS;
  wire wr_auth = wr_r && wadr_r == sgcs_pkg::AUTH_CNT_OFS;
  wire wr_ovl = wr_r && wadr_r == sgcs_pkg::OVL_CNT_OFS;
  wire wr_lock = wr_r && wadr_r == sgcs_pkg::LOCK_CNT_OFS;
  wire [7:0] radr = haddr[7:0];
  wire [31:0] rd_mux =
    (radr == sgcs_pkg::CTRL_OFS) ? {{(32 - sgcs_pkg::CTRL_W){1'b0}}, ctrl_r} :
    (radr == sgcs_pkg::TRAVEL_OFS) ? 32'(travel_r) :
    (radr == sgcs_pkg::HOLD_OFS) ? 32'(hold_r) :
    (radr == sgcs_pkg::BYPASS_OFS) ? 32'(bypass_r) :
    (radr == sgcs_pkg::SYNC_OFS) ? 32'(sync_r) :
    (radr == sgcs_pkg::STATUS_OFS) ? status_w :
    (radr == sgcs_pkg::AUTH_CNT_OFS) ? 32'(auth_cnt_r) :
    (radr == sgcs_pkg::OVL_CNT_OFS) ? 32'(ovl_cnt_r) :
    (radr == sgcs_pkg::LOCK_CNT_OFS) ? 32'(lock_cnt_r) :
    (radr == sgcs_pkg::TRIP_MASK_OFS) ? 32'(trip_mask_r) : 32'h0;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_r <= 1'b0;
      wadr_r <= 8'h00;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_r <= ap_valid && hwrite;
      wadr_r <= haddr[7:0];
      if (ap_valid && !hwrite) begin
        hrdata <= rd_mux;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= sgcs_pkg::CTRL_RST;
      travel_r <= TW'(sgcs_pkg::TRAVEL_RST);
      hold_r <= TW'(sgcs_pkg::HOLD_RST);
      bypass_r <= TW'(sgcs_pkg::BYPASS_RST);
      sync_r <= TW'(sgcs_pkg::SYNC_RST);
      trip_mask_r <= '0;
    end else if (wr_r) begin
      if (wr_ctrl) begin
        ctrl_r <= hwdata[sgcs_pkg::CTRL_W-1:0];
      end
      if (wadr_r == sgcs_pkg::TRAVEL_OFS) begin
        travel_r <= hwdata[TW-1:0];
      end
      if (wadr_r == sgcs_pkg::HOLD_OFS) begin
        hold_r <= hwdata[TW-1:0];
      end
      if (wadr_r == sgcs_pkg::BYPASS_OFS) begin
        bypass_r <= hwdata[TW-1:0];
      end
      if (wadr_r == sgcs_pkg::SYNC_OFS) begin
        sync_r <= hwdata[TW-1:0];
      end
      if (wadr_r == sgcs_pkg::TRIP_MASK_OFS) begin
        trip_mask_r <= hwdata[NTRIP-1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Configuration decode
  wire [1:0] auth = ctrl_r[sgcs_pkg::AUTH_LSB +: 2];
  wire [1:0] byp_mode = ctrl_r[sgcs_pkg::BYP_MODE_LSB +: 2];
  wire trip_latch = ctrl_r[sgcs_pkg::TRIP_LATCH_BIT];
  wire ovr_en = ctrl_r[sgcs_pkg::OVR_EN_BIT];
  wire ovr_pos = ctrl_r[sgcs_pkg::OVR_POS_BIT];
  wire aux_assigned = ctrl_r[sgcs_pkg::AUX_ASSIGNED_BIT];
  wire sync_assigned = ctrl_r[sgcs_pkg::SYNC_ASSIGNED_BIT];
  wire param_lock = ctrl_r[sgcs_pkg::PARAM_LOCK_BIT];
  wire [2:0] ilk_open_en = ctrl_r[sgcs_pkg::ILK_OPEN_LSB +: sgcs_pkg::NUM_ILK];
  wire [2:0] ilk_close_en = ctrl_r[sgcs_pkg::ILK_CLOSE_LSB +: sgcs_pkg::NUM_ILK];
  wire cmd_open = wr_cmd && hwdata[sgcs_pkg::CMD_OPEN_BIT];
  wire cmd_close = wr_cmd && hwdata[sgcs_pkg::CMD_CLOSE_BIT];
  wire cmd_byp_arm = wr_cmd && hwdata[sgcs_pkg::CMD_BYP_ARM_BIT];
  wire cmd_trip_rst = wr_cmd && hwdata[sgcs_pkg::CMD_TRIP_RST_BIT];

  ////////////////////////////////////////////////////////////////////////////////
  // Trip manager
  logic trip_r;
  logic [TW-1:0] hold_cnt_r;
  wire trip_any = |(s_trip & trip_mask_r) && !s_prot_block;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      trip_r <= 1'b0;
      hold_cnt_r <= '0;
    end else if (trip_any) begin
      trip_r <= 1'b1;
      hold_cnt_r <= hold_r;
    end else if (hold_cnt_r != '0) begin
      hold_cnt_r <= tdec(hold_cnt_r);
    end else if (!trip_latch || cmd_trip_rst) begin
      trip_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interlock bypass
  logic byp_run_r, byp_single_r;
  logic [TW-1:0] byp_cnt_r;
  logic used_bypass;
  wire byp_on = (byp_mode == sgcs_pkg::BYP_PERM) ||
                (byp_mode == sgcs_pkg::BYP_SIGNAL && s_byp_sig) ||
                (byp_mode == sgcs_pkg::BYP_TIMED && byp_run_r) ||
                (byp_mode == sgcs_pkg::BYP_SINGLE && byp_run_r && byp_single_r);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      byp_run_r <= 1'b0;
      byp_single_r <= 1'b0;
      byp_cnt_r <= '0;
    end else if (cmd_byp_arm) begin
      byp_run_r <= 1'b1;
      byp_single_r <= 1'b1;
      byp_cnt_r <= bypass_r;
    end else begin
      if (byp_cnt_r == '0) begin
        byp_run_r <= 1'b0;
      end
      byp_cnt_r <= tdec(byp_cnt_r);
      if (used_bypass) begin
        byp_single_r <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Position derivation
  sgcs_pkg::sgcs_state_t state_r, state_nxt;
  logic fault_r, fault_nxt;
  logic success_nxt;
  logic [TW-1:0] tmr_r, tmr_nxt;
  wire moving = state_r == sgcs_pkg::ST_MOVE_OPEN || state_r == sgcs_pkg::ST_MOVE_CLOSE;
  wire [1:0] pos_raw = !aux_assigned ? sgcs_pkg::POS_DISTURB :
                       fault_r ? sgcs_pkg::POS_DISTURB :
                       moving && contact != (state_r == sgcs_pkg::ST_MOVE_CLOSE) ?
                       sgcs_pkg::POS_INTERM :
                       contact ? sgcs_pkg::POS_CLOSED :
                       sgcs_pkg::POS_OPEN;
  wire [1:0] pos = ovr_en ? (ovr_pos ? sgcs_pkg::POS_CLOSED : sgcs_pkg::POS_OPEN) : pos_raw;

  ////////////////////////////////////////////////////////////////////////////////
  // Command sources and admission
  wire auth_local = auth == sgcs_pkg::AUTH_LOCAL || auth == sgcs_pkg::AUTH_BOTH;
  wire auth_remote = auth == sgcs_pkg::AUTH_REMOTE || auth == sgcs_pkg::AUTH_BOTH;
  wire pan_open = pin_rise[1];
  wire pan_close = pin_rise[2];
  wire ext_close_ev = pin_rise[4];
  wire ar_close = pin_rise[5];
  wire rem_open = cmd_open || s_ext_open;
  wire rem_close = cmd_close || ext_close_ev;
  wire pan_any = pan_open || pan_close;
  wire rem_ev = cmd_open || cmd_close || ext_close_ev || ar_close;
  wire want_open = (pan_open && auth_local) || (rem_open && auth_remote);
  wire want_close = ((pan_close && auth_local) || (rem_close && auth_remote)) && !want_open;
  wire busy = state_r != sgcs_pkg::ST_IDLE;
  wire ev_allowed = (pan_any && auth_local) || (rem_ev && auth_remote);
  wire rej_auth = (pan_any || rem_ev) && !ev_allowed;
  wire rej_lock = ev_allowed && param_lock;
  wire rej_ovl = ev_allowed && !param_lock && busy;
  wire ilk_open_blk = |(s_ilk_open & ilk_open_en);
  wire ilk_close_blk = |(s_ilk_close & ilk_close_en);
  wire go_open = want_open && !param_lock && !busy && pos != sgcs_pkg::POS_OPEN &&
                 (!ilk_open_blk || byp_on);
  wire go_close = want_close && !param_lock && !busy && pos != sgcs_pkg::POS_CLOSED &&
                  (!ilk_close_blk || byp_on);
  wire go_ar = ar_close && auth_remote && !busy && pos != sgcs_pkg::POS_CLOSED;
  wire go_trip = trip_r && pos != sgcs_pkg::POS_OPEN && state_r != sgcs_pkg::ST_MOVE_OPEN;
  wire sync_ok = !sync_assigned || s_sync;
  assign used_bypass = (go_open && ilk_open_blk) || (go_close && ilk_close_blk);

  ////////////////////////////////////////////////////////////////////////////////
  // Command sequencer
  always_comb begin
    state_nxt = state_r;
    tmr_nxt = tdec(tmr_r);
    fault_nxt = fault_r;
    success_nxt = 1'b0;
    if (go_trip || go_open) begin
      state_nxt = sgcs_pkg::ST_MOVE_OPEN;
      tmr_nxt = travel_r;
      fault_nxt = 1'b0;
    end else if (go_close || go_ar) begin
      fault_nxt = 1'b0;
      if (sync_ok) begin
        state_nxt = sgcs_pkg::ST_MOVE_CLOSE;
        tmr_nxt = travel_r;
      end else begin
        state_nxt = sgcs_pkg::ST_SYNC_WAIT;
        tmr_nxt = sync_r;
      end
    end else begin
      unique case (state_r)
        sgcs_pkg::ST_IDLE: begin
          tmr_nxt = tmr_r;
        end
        sgcs_pkg::ST_SYNC_WAIT: begin
          if (sync_ok) begin
            state_nxt = sgcs_pkg::ST_MOVE_CLOSE;
            tmr_nxt = travel_r;
          end else if (tmr_r == '0) begin
            state_nxt = sgcs_pkg::ST_IDLE;
          end
        end
        sgcs_pkg::ST_MOVE_OPEN: begin
          if (!contact) begin
            state_nxt = sgcs_pkg::ST_IDLE;
            success_nxt = 1'b1;
          end else if (tmr_r == '0) begin
            state_nxt = sgcs_pkg::ST_IDLE;
            fault_nxt = 1'b1;
          end
        end
        sgcs_pkg::ST_MOVE_CLOSE: begin
          if (contact) begin
            state_nxt = sgcs_pkg::ST_IDLE;
            success_nxt = 1'b1;
          end else if (tmr_r == '0) begin
            state_nxt = sgcs_pkg::ST_IDLE;
            fault_nxt = 1'b1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= sgcs_pkg::ST_IDLE;
      tmr_r <= '0;
      fault_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      tmr_r <= tmr_nxt;
      fault_r <= fault_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Rejection counters, write clears
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      auth_cnt_r <= '0;
      ovl_cnt_r <= '0;
      lock_cnt_r <= '0;
    end else begin
      if (rej_auth) begin
        auth_cnt_r <= sat_inc(auth_cnt_r);
      end else if (wr_auth) begin
        auth_cnt_r <= '0;
      end
      if (rej_ovl) begin
        ovl_cnt_r <= sat_inc(ovl_cnt_r);
      end else if (wr_ovl) begin
        ovl_cnt_r <= '0;
      end
      if (rej_lock) begin
        lock_cnt_r <= sat_inc(lock_cnt_r);
      end else if (wr_lock) begin
        lock_cnt_r <= '0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Registered outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      open_relay <= 1'b0;
      close_relay <= 1'b0;
      trip_out <= 1'b0;
      pos_state <= sgcs_pkg::POS_DISTURB;
      pos_open <= 1'b0;
      pos_closed <= 1'b0;
      pos_interm <= 1'b0;
      pos_disturbed <= 1'b1;
      command_success <= 1'b0;
      pos_fault <= 1'b0;
      override_active <= 1'b0;
      bypass_active <= 1'b0;
    end else begin
      open_relay <= state_r == sgcs_pkg::ST_MOVE_OPEN || trip_r;
      close_relay <= state_r == sgcs_pkg::ST_MOVE_CLOSE;
      trip_out <= trip_r;
      pos_state <= pos;
      pos_open <= pos == sgcs_pkg::POS_OPEN;
      pos_closed <= pos == sgcs_pkg::POS_CLOSED;
      pos_interm <= pos == sgcs_pkg::POS_INTERM;
      pos_disturbed <= pos == sgcs_pkg::POS_DISTURB;
      command_success <= success_nxt;
      pos_fault <= fault_r;
      override_active <= ovr_en;
      bypass_active <= byp_on;
    end
  end

  assign status_w = {22'h000000, byp_on, ovr_en, busy, trip_r, fault_r, contact,
                     state_r, pos};
endmodule

// ==== dv/sgcs_breaker.sv ====
// Breaker model with open-side auxiliary contact
`timescale 1ns/100ps
module sgcs_breaker #(
  parameter int DLY = 6
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic open_relay,
  input wire logic close_relay,
  input wire logic stuck,
  output logic aux_open_contact
);
  int cnt;
  ////////////////////////////////////////////////////////////////////////////////
  // Moves after coil energised DLY+1 cycles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 0;
      aux_open_contact <= 1'b0;
    end else if ((open_relay || close_relay) && !stuck) begin
      cnt <= cnt + 1;
      if (cnt == DLY) begin
        // Trip coil wins over close coil
        aux_open_contact <= !open_relay;
      end
    end else begin
      cnt <= 0;
    end
  end
endmodule

// ==== dv/sgcs_top_asserts.sv ====
// Supervisor port assertions
`timescale 1ns/100ps
module sgcs_top_asserts (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic key_close,
  input wire logic open_relay,
  input wire logic close_relay,
  input wire logic trip_out,
  input wire logic [1:0] pos_state,
  input wire logic pos_open,
  input wire logic pos_closed,
  input wire logic pos_interm,
  input wire logic pos_disturbed,
  input wire logic command_success,
  input wire logic pos_fault,
  input wire logic override_active
);
  logic close_q;
  logic held_r;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  ////////////////////////////////////////////////////////////////////////////////
  // Key held since close pulse
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      close_q <= 1'b0;
      held_r <= 1'b0;
    end else begin
      close_q <= close_relay;
      held_r <= key_close && (held_r || (close_relay && !close_q));
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  property p_pos_code;
    pos_open == (pos_state == sgcs_pkg::POS_OPEN) && pos_closed == (pos_state == sgcs_pkg::POS_CLOSED)
      && pos_interm == (pos_state == sgcs_pkg::POS_INTERM)
      && pos_disturbed == (pos_state == sgcs_pkg::POS_DISTURB);
  endproperty
  a_pos_code: assert property (p_pos_code) else $error("position flags disagree");
  property p_interm;
    (close_relay || (open_relay && !trip_out && !$past(trip_out))) && !override_active
      && !command_success |-> pos_interm;
  endproperty
  a_interm: assert property (p_interm) else $error("travel without intermediate");
  property p_success;
    command_success |-> !pos_interm && !pos_disturbed;
  endproperty
  a_success: assert property (p_success) else $error("success with intermediate");
  property p_success_pulse;
    command_success |=> !command_success;
  endproperty
  a_success_pulse: assert property (p_success_pulse) else $error("success too long");
  property p_fault;
    $rose(pos_fault) |-> pos_disturbed && !pos_interm;
  endproperty
  a_fault: assert property (p_fault) else $error("fault without disturbed");
  property p_trip;
    trip_out |-> ##[0:2] open_relay;
  endproperty
  a_trip: assert property (p_trip) else $error("trip not driving open relay");
  property p_anti_pump;
    close_relay && !close_q |-> !held_r;
  endproperty
  a_anti_pump: assert property (p_anti_pump) else $error("second close pulse");
  property p_okay;
    hsel && htrans[1] && hready |=> hreadyout && !hresp;
  endproperty
  a_okay: assert property (p_okay) else $error("bus not ready or error");
  property p_rdata;
    !$stable(hrdata) |-> $past(hsel && htrans[1] && hready && !hwrite);
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data moved");
endmodule
bind sgcs_top sgcs_top_asserts u_chk (.*);

// ==== dv/tb_switchgear_command_supervisor.sv ====
// Self-checking supervisor bench
`timescale 1ns/100ps
module tb_switchgear_command_supervisor;
  typedef struct packed {logic [1:0] auth; logic [1:0] src; logic acc;} sgcs_row_t;
  logic hclk;
  logic hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, stuck = 1'b0, key_close = 1'b0;
  logic ext_open = 1'b0, ext_close = 1'b0, auto_reclose = 1'b0, sync_release = 1'b0;
  logic prot_block = 1'b0, cq = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0, pos_state;
  logic [2:0] ilk_open = 3'h0, ilk_close = 3'h0;
  logic [7:0] prot_trip = 8'h00;
  logic hreadyout, hresp, aux_open_contact, open_relay, close_relay, trip_out, pos_open;
  logic pos_closed, pos_interm, pos_disturbed, command_success, pos_fault;
  logic override_active, bypass_active;
  int n_fail = 0, cmp_count = 0, n_close = 0, n_succ = 0, k = 0, exp_auth = 0;
  // Source: 0 key, 1 register, 2 external, 3 reclose
  sgcs_row_t rows [10] = '{'{2'h0, 2'h0, 1'b0}, '{2'h0, 2'h1, 1'b0}, '{2'h1, 2'h0, 1'b1},
    '{2'h1, 2'h2, 1'b0}, '{2'h1, 2'h3, 1'b0}, '{2'h2, 2'h1, 1'b1}, '{2'h2, 2'h0, 1'b0},
    '{2'h2, 2'h3, 1'b1}, '{2'h3, 2'h2, 1'b1}, '{2'h3, 2'h0, 1'b1}};
  sgcs_top DUT (.*, .hsize(3'h2), .hready(hreadyout), .key_open(1'b0), .bypass_signal(1'b0));
  sgcs_breaker u_brk (.*);
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk) begin
    cq <= close_relay;
    if (close_relay === 1'b1 && cq !== 1'b1) n_close++;
    if (command_success === 1'b1) n_succ++;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", n, e, g);
      n_fail++;
    end
  endtask
  task automatic chkr(input string n, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 32'h0, q);
    chk(n, e, q);
  endtask
  task automatic ctrl(input logic [15:0] v);
    wr(sgcs_pkg::CTRL_OFS, {16'h0, v});
  endtask
  task automatic cmd(input logic [3:0] b);
    wr(sgcs_pkg::CMD_OFS, {28'h0, b});
  endtask
  task automatic settle;
    repeat (30) @(posedge hclk);
  endtask
  task automatic cfg;
    wr(sgcs_pkg::TRAVEL_OFS, 32'h14);
    wr(sgcs_pkg::HOLD_OFS, 32'h08);
    wr(sgcs_pkg::BYPASS_OFS, 32'h1e);
    wr(sgcs_pkg::SYNC_OFS, 32'h0f);
    wr(sgcs_pkg::TRIP_MASK_OFS, 32'h01);
  endtask
  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    report_and_stop;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    cfg;
    for (int i = 0; i < 10; i++) begin
      ctrl(16'h0080 | {14'h0, rows[i].auth});
      k = n_close;
      case (rows[i].src)
        2'h0: key_close <= 1'b1;
        2'h1: cmd(4'h2);
        2'h2: ext_close <= 1'b1;
        default: auto_reclose <= 1'b1;
      endcase
      settle;
      key_close <= 1'b0;
      ext_close <= 1'b0;
      auto_reclose <= 1'b0;
      chk("row pos", rows[i].acc ? 32'h2 : 32'h1, 32'(pos_state));
      chk("row pulses", 32'(rows[i].acc), 32'(n_close - k));
      exp_auth += 32'(!rows[i].acc);
      chkr("auth count", sgcs_pkg::AUTH_CNT_OFS, 32'(exp_auth));
      if (rows[i].acc) begin
        ctrl(16'h0083);
        cmd(4'h1);
        settle;
      end
    end
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("reset pos", 32'(sgcs_pkg::POS_DISTURB), 32'(pos_state));
    hresetn <= 1'b1;
    chkr("ctrl", sgcs_pkg::CTRL_OFS, 32'(sgcs_pkg::CTRL_RST));
    chkr("travel", sgcs_pkg::TRAVEL_OFS, sgcs_pkg::TRAVEL_RST);
    chkr("bypass", sgcs_pkg::BYPASS_OFS, sgcs_pkg::BYPASS_RST);
    chkr("unmapped", 8'h3c, 32'h0);
    cfg;
    cmd(4'h2);
    settle;
    stuck <= 1'b1;
    cmd(4'h1);
    repeat (8) @(posedge hclk);
    chk("interm", 32'h1, 32'(pos_interm));
    settle;
    chk("fault", 32'h1, 32'(pos_fault));
    chk("fault pos", 32'(sgcs_pkg::POS_DISTURB), 32'(pos_state));
    stuck <= 1'b0;
    k = n_succ;
    cmd(4'h1);
    settle;
    chk("open pos", 32'h1, 32'(pos_state));
    chk("success", 32'(k + 1), 32'(n_succ));
    cmd(4'h2);
    cmd(4'h1);
    settle;
    chk("overlap pos", 32'h2, 32'(pos_state));
    chkr("overlap count", sgcs_pkg::OVL_CNT_OFS, 32'h1);
    k = n_close;
    cmd(4'h2);
    settle;
    chk("same dir", 32'h0, 32'(n_close - k));
    prot_trip <= 8'h02;
    settle;
    chk("unassigned trip", 32'h0, 32'(trip_out));
    prot_block <= 1'b1;
    prot_trip <= 8'h01;
    settle;
    chk("blocked trip", 32'h2, 32'(pos_state));
    prot_block <= 1'b0;
    ctrl(16'h0483);
    ilk_open <= 3'h1;
    repeat (15) @(posedge hclk);
    prot_trip <= 8'h00;
    repeat (4) @(posedge hclk);
    chk("trip hold", 32'h1, 32'(trip_out));
    settle;
    chk("trip end", 32'h0, 32'(trip_out));
    chk("trip pos", 32'h1, 32'(pos_state));
    ilk_open <= 3'h0;
    ctrl(16'h2083);
    ilk_close <= 3'h1;
    cmd(4'h2);
    settle;
    chk("interlock", 32'h1, 32'(pos_state));
    ctrl(16'h2087);
    cmd(4'h2);
    settle;
    chk("bypass flag", 32'h1, 32'(bypass_active));
    chk("bypass pos", 32'h2, 32'(pos_state));
    ilk_close <= 3'h0;
    ctrl(16'h0083);
    k = n_close;
    ext_open <= 1'b1;
    ext_close <= 1'b1;
    settle;
    chk("ext open", 32'h1, 32'(pos_state));
    chk("ext close", 32'h0, 32'(n_close - k));
    ext_open <= 1'b0;
    ext_close <= 1'b0;
    ctrl(16'h0183);
    cmd(4'h2);
    settle;
    chk("sync expiry", 32'h1, 32'(pos_state));
    cmd(4'h2);
    repeat (6) @(posedge hclk);
    sync_release <= 1'b1;
    settle;
    chk("sync close", 32'h2, 32'(pos_state));
    sync_release <= 1'b0;
    ctrl(16'h00a3);
    repeat (4) @(posedge hclk);
    chk("override", 32'h1, 32'(override_active));
    chk("override pos", 32'h1, 32'(pos_state));
    ctrl(16'h0283);
    cmd(4'h1);
    chkr("lock count", sgcs_pkg::LOCK_CNT_OFS, 32'h1);
    ctrl(16'h0003);
    repeat (4) @(posedge hclk);
    chk("no aux", 32'(sgcs_pkg::POS_DISTURB), 32'(pos_state));
    report_and_stop;
  end
endmodule
